//--- verilog/pct_top.sv
// auto-reload pwm timer with input capture and tick unit, apb slave
`timescale 1ns/1ps
module pct_top
	import pct_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PCT_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] capIn,
	input wire logic extClkIn,
	input wire logic halt,
	input wire logic cpuIntMask,
	output logic [1:0] pwmOut,
	output logic [1:0] pwmOe,
	output logic artIrq,
	output logic [1:0] capIrq,
	output logic tickIrq
);
	typedef struct packed {
		logic [1:0][7:0] duty;
		logic [1:0][7:0] cmp;
		logic [7:0] pwm_ctrl_reg;
		logic [7:0] csr;
		logic [7:0] cnt;
		logic [6:0] presc;
		logic extPrev;
		logic [7:0] reload_value_reg;
		logic [3:0] capCtl;
		logic [7:0] tickCtl;
		logic [1:0] pwmOut;
		logic [7:0] rdata;
	} pct_top_st_t;
	pct_top_st_t st_r;
	pct_top_st_t st_nxt;

	pct_link_if lnk ();

	logic [5:0] idx;
	logic mapped;
	logic [7:0] rdVal;
	logic acc;
	logic wr;
	logic rd;
	logic [7:0] wdata;
	logic [2:0] cc;
	logic [6:0] ccMask;
	logic srcTick;
	logic artTick;
	logic artOvf;
	logic [1:0] lvl;
	logic [1:0] op;
	logic [1:0] oe;

	////////////////////////////////////////////////////////////////////
	// helper units
	pct_capture u_cap (
		.core_clk(core_clk),
		.rst(rst),
		.lnk(lnk.cap)
	);

	pct_tick_unit u_tick (
		.core_clk(core_clk),
		.rst(rst),
		.lnk(lnk.tick)
	);

	////////////////////////////////////////////////////////////////////
	// apb decode: zero wait states, read data latched in setup
	assign idx = paddr[PCT_AW-1:2];
	assign acc = psel && penable;
	assign wr = acc && pwrite && mapped;
	assign rd = acc && !pwrite && mapped;
	assign wdata = pwdata[7:0];
	assign pready = 1'b1;
	assign pslverr = acc && !mapped;

	always_comb begin
		mapped = (paddr[1:0] == 2'b00);
		rdVal = PCT_RST;
		case (idx)
			PCT_IDX_DUTY1: begin
				rdVal = st_r.duty[1];
			end
			PCT_IDX_DUTY0: begin
				rdVal = st_r.duty[0];
			end
			PCT_IDX_PWM_CTRL_REG: begin
				rdVal = st_r.pwm_ctrl_reg;
			end
			PCT_IDX_CSR: begin
				rdVal = st_r.csr;
			end
			PCT_IDX_CAR: begin
				rdVal = st_r.cnt;
			end
			PCT_IDX_ARR: begin
				rdVal = st_r.reload_value_reg;
			end
			PCT_IDX_CAPCSR: begin
				rdVal = {2'b00, st_r.capCtl, lnk.capFlag};
			end
			PCT_IDX_CAPV1: begin
				rdVal = lnk.capVal[0];
			end
			PCT_IDX_CAPV2: begin
				rdVal = lnk.capVal[1];
			end
			PCT_IDX_TICKCV: begin
				rdVal = lnk.tickCount;
			end
			PCT_IDX_TICKCSR: begin
				rdVal = st_r.tickCtl;
				rdVal[PCT_TOVF_BIT] = lnk.tickOvf;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// reload counter clocking
	assign cc = st_r.csr[PCT_CC_LSB +: 3];
	assign ccMask = 7'h7f >> (3'd7 - cc);
	assign srcTick = st_r.csr[PCT_EXCL_BIT] ?
		(extClkIn && !st_r.extPrev) : 1'b1;
	assign artTick = st_r.csr[PCT_TCE_BIT] && !halt && srcTick &&
		((st_r.presc & ccMask) == ccMask);
	assign artOvf = artTick && (st_r.cnt == PCT_FULL);
	assign op = st_r.pwm_ctrl_reg[PCT_OP_LSB +: 2];
	assign oe = st_r.pwm_ctrl_reg[PCT_OE_LSB +: 2];

	// per-channel compare level
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_pwm
			always_comb begin
				if (st_r.cmp[gi] == PCT_FULL) begin
					lvl[gi] = 1'b0;
				end else if (st_r.cmp[gi] == PCT_ZERO) begin
					lvl[gi] = 1'b1;
				end else begin
					lvl[gi] = (st_r.cnt <= st_r.cmp[gi]);
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.extPrev = extClkIn;
		if (acc == 1'b0 && psel) begin
			st_nxt.rdata = rdVal;
		end
		// pwm pins follow the level with polarity applied live
		st_nxt.pwmOut = oe & (lvl ^ op);
		if (st_r.csr[PCT_TCE_BIT] && !halt && srcTick) begin
			st_nxt.presc = 7'(st_r.presc + 7'h01);
		end
		if (artOvf) begin
			st_nxt.cnt = st_r.reload_value_reg;
			st_nxt.cmp = st_r.duty;
		end else if (artTick) begin
			st_nxt.cnt = 8'(st_r.cnt + 8'h01);
		end
		// read clears only the flag value that was returned
		if (rd && idx == PCT_IDX_CSR) begin
			st_nxt.csr[PCT_AOVF_BIT] = st_r.csr[PCT_AOVF_BIT] &
				!st_r.rdata[PCT_AOVF_BIT];
		end
		if (artOvf) begin
			st_nxt.csr[PCT_AOVF_BIT] = 1'b1;
		end
		if (wr) begin
			case (idx)
				PCT_IDX_DUTY1: begin
					st_nxt.duty[1] = wdata;
				end
				PCT_IDX_DUTY0: begin
					st_nxt.duty[0] = wdata;
				end
				PCT_IDX_PWM_CTRL_REG: begin
					st_nxt.pwm_ctrl_reg = wdata & PCT_PWM_CTRL_REG_WMASK;
				end
				PCT_IDX_CSR: begin
					st_nxt.csr = (wdata & PCT_CSR_WMASK) |
						(st_nxt.csr & ~PCT_CSR_WMASK);
					if (wdata[PCT_FCRL_BIT]) begin
						st_nxt.cnt = st_r.reload_value_reg;
						st_nxt.presc = '0;
					end
				end
				PCT_IDX_CAR: begin
					st_nxt.cnt = wdata;
					st_nxt.presc = '0;
				end
				PCT_IDX_ARR: begin
					st_nxt.reload_value_reg = wdata;
				end
				PCT_IDX_CAPCSR: begin
					st_nxt.capCtl = wdata[PCT_CIE_LSB +: 4];
				end
				PCT_IDX_TICKCSR: begin
					st_nxt.tickCtl = wdata & PCT_TCSR_WMASK;
				end
				default: begin
					st_nxt.rdata = st_r.rdata;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// link to helper units
	assign lnk.cnt = st_r.cnt;
	assign lnk.halt = halt;
	assign lnk.capIn = capIn;
	assign lnk.capEdge = st_r.capCtl[PCT_CS_LSB - PCT_CIE_LSB +: 2];
	assign lnk.capClr = (rd && idx == PCT_IDX_CAPCSR) ?
		st_r.rdata[PCT_CF_LSB +: 2] : 2'b00;
	assign lnk.tick_run_enable = st_r.tickCtl[PCT_TICK_RUN_ENABLE_BIT];
	assign lnk.cas = st_r.tickCtl[PCT_CAS_BIT];
	assign lnk.pr = st_r.tickCtl[PCT_PR_LSB +: 3];
	assign lnk.artCarry = artOvf;
	assign lnk.tickWr = wr && idx == PCT_IDX_TICKCV;
	assign lnk.tickWrData = wdata;
	assign lnk.tickRdClr = rd && idx == PCT_IDX_TICKCSR &&
		st_r.rdata[PCT_TOVF_BIT];

	////////////////////////////////////////////////////////////////////
	// outputs
	assign prdata = {24'h00_0000, st_r.rdata};
	assign pwmOut = st_r.pwmOut;
	assign pwmOe = oe;
	assign artIrq = st_r.csr[PCT_OIE_BIT] && st_r.csr[PCT_AOVF_BIT];
	assign capIrq = lnk.capFlag & st_r.capCtl[1:0];
	assign tickIrq = lnk.tickOvf && st_r.tickCtl[PCT_ITE_BIT] &&
		!cpuIntMask;

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	AST_RELOAD: assert property (
		artOvf && !wr |=> st_r.cnt == $past(st_r.reload_value_reg))
		else $error("counter not reloaded on overflow");
	AST_SHADOW: assert property (
		artOvf |=> st_r.cmp == $past(st_r.duty))
		else $error("compare shadow not reloaded");
	AST_OE_OFF: assert property (!oe[0] |=> !pwmOut[0])
		else $error("disabled pwm pin 0 driven high");
	AST_OE_OFF1: assert property (!oe[1] |=> !pwmOut[1])
		else $error("disabled pwm pin 1 driven high");
	AST_DUTY_FF: assert property (
		st_r.cmp[1] == PCT_FULL && !op[1] && oe[1] |=> !pwmOut[1])
		else $error("duty ff did not hold output low");
	AST_DUTY_00: assert property (
		st_r.cmp[0] == PCT_ZERO && !op[0] && oe[0] |=> pwmOut[0])
		else $error("duty 00 did not hold output high");
	AST_DUTY_00_CH1: assert property (
		st_r.cmp[1] == PCT_ZERO && !op[1] && oe[1] |=> pwmOut[1])
		else $error("duty 00 did not hold channel 1 high");
	AST_PWM_LEVEL: assert property (
		oe[0] && !op[0] && st_r.cmp[0] != PCT_FULL &&
		st_r.cmp[0] != PCT_ZERO
		|=> pwmOut[0] == ($past(st_r.cnt) <= $past(st_r.cmp[0])))
		else $error("pwm level does not follow compare");
	AST_POL_LIVE: assert property (
		oe[0] && $stable(oe[0]) && $changed(op[0])
		&& $stable(st_r.cnt) && $stable(st_r.cmp[0])
		|=> pwmOut[0] != $past(pwmOut[0]))
		else $error("polarity change did not invert output");
	AST_TICK_IRQ: assert property (
		tickIrq |-> st_r.tickCtl[PCT_ITE_BIT] &&
		!cpuIntMask && lnk.tickOvf)
		else $error("tick irq without enable");
	AST_CAP_IRQ: assert property (capIrq[0] |-> st_r.capCtl[0])
		else $error("capture irq 0 without enable");
	AST_CAP_IRQ1: assert property (capIrq[1] |-> st_r.capCtl[1])
		else $error("capture irq 1 without enable");
	AST_TICK_BIT7: assert property (
		rd && idx == PCT_IDX_TICKCSR |-> !prdata[7])
		else $error("tick control bit 7 read as one");
	AST_CAP_RSVD: assert property (
		rd && idx == PCT_IDX_CAPCSR |-> prdata[7:6] == 2'b00)
		else $error("capture control bits 7:6 read nonzero");
endmodule : pct_top

//--- verilog/pct_pkg.sv
// constants for the pwm / capture timer and its tick unit
package pct_pkg;
	// register indices; byte address is four times the index
	localparam logic [5:0] PCT_IDX_DUTY1 = 6'h14;
	localparam logic [5:0] PCT_IDX_DUTY0 = 6'h15;
	localparam logic [5:0] PCT_IDX_PWM_CTRL_REG = 6'h16;
	localparam logic [5:0] PCT_IDX_CSR = 6'h17;
	localparam logic [5:0] PCT_IDX_CAR = 6'h18;
	localparam logic [5:0] PCT_IDX_ARR = 6'h19;
	localparam logic [5:0] PCT_IDX_CAPCSR = 6'h1a;
	localparam logic [5:0] PCT_IDX_CAPV1 = 6'h1b;
	localparam logic [5:0] PCT_IDX_CAPV2 = 6'h1c;
	localparam logic [5:0] PCT_IDX_TICKCV = 6'h36;
	localparam logic [5:0] PCT_IDX_TICKCSR = 6'h37;
	localparam int PCT_AW = 8;
	localparam logic [7:0] PCT_RST = 8'h00;
	localparam logic [7:0] PCT_FULL = 8'hff;
	localparam logic [7:0] PCT_ZERO = 8'h00;
	// pwm control fields
	localparam int PCT_OE_LSB = 4;
	localparam int PCT_OP_LSB = 0;
	localparam logic [7:0] PCT_PWM_CTRL_REG_WMASK = 8'h33;
	// reload timer control / status fields
	localparam int PCT_EXCL_BIT = 7;
	localparam int PCT_CC_LSB = 4;
	localparam int PCT_TCE_BIT = 3;
	localparam int PCT_FCRL_BIT = 2;
	localparam int PCT_OIE_BIT = 1;
	localparam int PCT_AOVF_BIT = 0;
	localparam logic [7:0] PCT_CSR_WMASK = 8'hfa;
	// capture control / status fields
	localparam int PCT_CS_LSB = 4;
	localparam int PCT_CIE_LSB = 2;
	localparam int PCT_CF_LSB = 0;
	// tick unit control / status fields
	localparam int PCT_CAS_BIT = 6;
	localparam int PCT_TOVF_BIT = 5;
	localparam int PCT_ITE_BIT = 4;
	localparam int PCT_TICK_RUN_ENABLE_BIT = 3;
	localparam int PCT_PR_LSB = 0;
	localparam logic [7:0] PCT_TCSR_WMASK = 8'h5f;
endpackage : pct_pkg

//--- verilog/pct_link_if.sv
// signals shared between the timer core and its two helper units
`timescale 1ns/1ps
interface pct_link_if;
	logic [7:0] cnt;
	logic halt;
	logic [1:0] capIn;
	logic [1:0] capEdge;
	logic [1:0] capClr;
	logic [1:0] capFlag;
	logic [1:0][7:0] capVal;
	logic tick_run_enable;
	logic cas;
	logic [2:0] pr;
	logic artCarry;
	logic tickWr;
	logic [7:0] tickWrData;
	logic tickRdClr;
	logic [7:0] tickCount;
	logic tickOvf;
	modport core (output cnt, halt, capIn, capEdge, capClr, tick_run_enable, cas, pr,
		artCarry, tickWr, tickWrData, tickRdClr,
		input capFlag, capVal, tickCount, tickOvf);
	modport cap (input cnt, halt, capIn, capEdge, capClr,
		output capFlag, capVal);
	modport tick (input halt, tick_run_enable, cas, pr, artCarry, tickWr, tickWrData,
		tickRdClr, output tickCount, tickOvf);
endinterface : pct_link_if

//--- verilog/pct_capture.sv
// two input capture channels with edge select and read-to-clear flags
`timescale 1ns/1ps
module pct_capture
	import pct_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	pct_link_if.cap lnk
);
	typedef struct packed {
		logic [1:0] prev;
		logic [1:0] flag;
		logic [1:0][7:0] val;
	} pct_cap_st_t;
	pct_cap_st_t st_r;
	pct_cap_st_t st_nxt;
	logic [1:0] hit;

	////////////////////////////////////////////////////////////////////
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ch
			// selected edge, ignored while halted
			assign hit[gi] = !lnk.halt && (lnk.capEdge[gi] ?
				(lnk.capIn[gi] && !st_r.prev[gi]) :
				(!lnk.capIn[gi] && st_r.prev[gi]));
		end
	endgenerate

	always_comb begin
		st_nxt = st_r;
		st_nxt.prev = lnk.capIn;
		st_nxt.flag = st_r.flag & ~lnk.capClr;
		for (int i = 0; i < 2; i++) begin
			// transfer blocked until the flag has been read away
			if (hit[i] && (!st_r.flag[i] || lnk.capClr[i])) begin
				st_nxt.val[i] = lnk.cnt;
				st_nxt.flag[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign lnk.capFlag = st_r.flag;
	assign lnk.capVal = st_r.val;

	////////////////////////////////////////////////////////////////////
	AST_CAP_VALUE: assert property (
		@(posedge core_clk) disable iff (rst)
		hit[0] && !st_r.flag[0] |=> st_r.val[0] == $past(lnk.cnt))
		else $error("capture value not taken from counter");
	AST_CAP_CLEAR: assert property (
		@(posedge core_clk) disable iff (rst)
		lnk.capClr[1] && !hit[1] |=> !st_r.flag[1])
		else $error("capture flag not cleared by read");
endmodule : pct_capture

//--- verilog/pct_tick_unit.sv
// 8-bit tick counter with prescaler, rollover flag and chaining
`timescale 1ns/1ps
module pct_tick_unit
	import pct_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	pct_link_if.tick lnk
);
	typedef struct packed {
		logic [7:0] count;
		logic [7:0] presc;
		logic ovf;
	} pct_tick_st_t;
	pct_tick_st_t st_r;
	pct_tick_st_t st_nxt;
	logic [7:0] mask;
	logic inc;

	////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		mask = PCT_FULL >> (3'd7 - lnk.pr);
		if (!lnk.tick_run_enable) begin
			st_nxt.presc = PCT_ZERO;
		end else if (!lnk.halt) begin
			st_nxt.presc = 8'(st_r.presc + 8'h01);
		end
		if (lnk.cas) begin
			inc = lnk.tick_run_enable && !lnk.halt && lnk.artCarry;
		end else begin
			inc = lnk.tick_run_enable && !lnk.halt &&
				((st_r.presc & mask) == mask);
		end
		if (lnk.tickRdClr) begin
			st_nxt.ovf = 1'b0;
		end
		if (inc) begin
			st_nxt.count = 8'(st_r.count + 8'h01);
			if (st_r.count == PCT_FULL) begin
				st_nxt.ovf = 1'b1;
			end
		end
		if (lnk.tickWr) begin
			st_nxt.count = lnk.tickWrData;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign lnk.tickCount = st_r.count;
	assign lnk.tickOvf = st_r.ovf;

	////////////////////////////////////////////////////////////////////
	AST_TICK_ROLL: assert property (
		@(posedge core_clk) disable iff (rst)
		inc && st_r.count == PCT_FULL && !lnk.tickWr
		|=> st_r.ovf && st_r.count == PCT_ZERO)
		else $error("rollover did not set flag and wrap");
	AST_TICK_FREEZE: assert property (
		@(posedge core_clk) disable iff (rst)
		!lnk.tick_run_enable && !lnk.tickWr
		|=> $stable(st_r.count) && st_r.presc == PCT_ZERO)
		else $error("tick counter moved while disabled");
	AST_TICK_HALT: assert property (
		@(posedge core_clk) disable iff (rst)
		lnk.halt && !lnk.tickWr |=> $stable(st_r.count))
		else $error("tick counter moved in halt");
	AST_TICK_WRITE: assert property (
		@(posedge core_clk) disable iff (rst)
		lnk.tickWr |=> st_r.count == $past(lnk.tickWrData))
		else $error("tick count write lost");
endmodule : pct_tick_unit

//--- testbench/pct_pulse_src.sv
// capture pulse source standing in for the external signal sources
`timescale 1ns/1ps
module pct_pulse_src (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [1:0] lvl,
	output logic [1:0] capIn
);
	////////////////////////////////////////////////////////////////////////
	// levels change only just after a rising edge; idle is ch1 low, ch2 high
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			capIn <= 2'b10;
		end else begin
			capIn <= lvl;
		end
	end
endmodule : pct_pulse_src

//--- testbench/tb.sv
// self-checking bench for the pwm / capture timer and its tick unit
`timescale 1ns/1ps
module tb
	import pct_pkg::*;
;
	logic core_clk, rst, psel, penable, pwrite, halt, cpuIntMask, extClkIn;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, artIrq, tickIrq, err;
	logic [1:0] capIn, pwmOut, pwmOe, capIrq, srcLvl;
	int badCount = 0;
	int checked = 0;
	int c;
	////////////////////////////////////////////////////////////////////////
	pct_top pct_top_inst (.core_clk(core_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .capIn(capIn),
		.extClkIn(extClkIn), .halt(halt), .cpuIntMask(cpuIntMask),
		.pwmOut(pwmOut), .pwmOe(pwmOe), .artIrq(artIrq), .capIrq(capIrq),
		.tickIrq(tickIrq));
	pct_pulse_src pct_pulse_src_inst (.core_clk(core_clk), .rst(rst),
		.lvl(srcLvl), .capIn(capIn));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			badCount++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [5:0] i,
		input logic [7:0] d, input logic [1:0] lo);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, lo};
		pwdata <= {24'h00_0000, d};
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [5:0] i, input logic [7:0] d);
		xfer(1'b1, i, d, 2'b00);
	endtask : wr
	task automatic rc(input logic [5:0] i, input logic [7:0] e);
		xfer(1'b0, i, 8'h00, 2'b00);
		chk(rd, {24'h00_0000, e});
	endtask : rc
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc
	task automatic hi(input int ch, input int n, output int cnt);
		cnt = 0;
		repeat (n) begin
			@(negedge core_clk);
			if (pwmOut[ch] === 1'b1) cnt++;
		end
	endtask : hi
	////////////////////////////////////////////////////////////////////////
	task automatic tRegs();
		for (int i = int'(PCT_IDX_DUTY1); i <= int'(PCT_IDX_CAPV2); i++) begin
			rc(6'(i), 8'h00);
			chk(32'(err), 32'h0000_0000);
		end
		rc(PCT_IDX_TICKCV, 8'h00);
		chk(32'(err), 32'h0000_0000);
		rc(PCT_IDX_TICKCSR, 8'h00);
		chk(32'(err), 32'h0000_0000);
		xfer(1'b0, 6'h00, 8'h00, 2'b00);
		chk(32'(err), 32'h0000_0001);
		xfer(1'b1, PCT_IDX_DUTY1, 8'h55, 2'b01);
		chk(32'(err), 32'h0000_0001);
		rc(PCT_IDX_DUTY1, 8'h00);
	endtask : tRegs
	task automatic tPwm();
		wr(PCT_IDX_DUTY0, 8'h00);
		wr(PCT_IDX_DUTY1, 8'hff);
		wr(PCT_IDX_PWM_CTRL_REG, 8'h30);
		wr(PCT_IDX_CSR, 8'h08);
		cyc(300);
		chk(32'(pwmOut), 32'h0000_0001);
		chk(32'(pwmOe), 32'h0000_0003);
		wr(PCT_IDX_PWM_CTRL_REG, 8'h33);
		cyc(2);
		chk(32'(pwmOut), 32'h0000_0002);
		wr(PCT_IDX_PWM_CTRL_REG, 8'hd1);
		cyc(2);
		chk(32'(pwmOut), 32'h0000_0000);
		chk(32'(pwmOe), 32'h0000_0001);
		rc(PCT_IDX_PWM_CTRL_REG, 8'h11);
		wr(PCT_IDX_PWM_CTRL_REG, 8'h30);
		wr(PCT_IDX_DUTY0, 8'h80);
		cyc(300);
		hi(0, 256, c);
		chk(32'(c), 32'h0000_0081);
		wr(PCT_IDX_ARR, 8'h80);
		wr(PCT_IDX_DUTY1, 8'hc0);
		cyc(300);
		hi(1, 128, c);
		chk(32'(c), 32'h0000_0041);
		hi(0, 128, c);
		chk(32'(c), 32'h0000_0001);
		wr(PCT_IDX_CSR, 8'h00);
	endtask : tPwm
	task automatic tCap();
		logic [7:0] cnt;
		wr(PCT_IDX_CAPCSR, 8'hc0);
		rc(PCT_IDX_CAPCSR, 8'h00);
		wr(PCT_IDX_CAPCSR, 8'h1c);
		xfer(1'b0, PCT_IDX_CAR, 8'h00, 2'b00);
		cnt = rd[7:0];
		@(posedge core_clk);
		srcLvl <= 2'b01;
		cyc(4);
		chk(32'(capIrq), 32'h0000_0003);
		rc(PCT_IDX_CAPV1, cnt);
		rc(PCT_IDX_CAPV2, cnt);
		rc(PCT_IDX_CAPCSR, 8'h1f);
		rc(PCT_IDX_CAPCSR, 8'h1c);
		chk(32'(capIrq), 32'h0000_0000);
		wr(PCT_IDX_CAPCSR, 8'h34);
		@(posedge core_clk);
		srcLvl <= 2'b10;
		cyc(4);
		chk(32'(capIrq), 32'h0000_0000);
		rc(PCT_IDX_CAPCSR, 8'h36);
	endtask : tCap
	task automatic tTick();
		logic [7:0] cnt;
		wr(PCT_IDX_TICKCV, 8'hfc);
		rc(PCT_IDX_TICKCV, 8'hfc);
		wr(PCT_IDX_TICKCSR, 8'hb8);
		cyc(20);
		chk(32'(tickIrq), 32'h0000_0001);
		@(posedge core_clk);
		cpuIntMask <= 1'b1;
		cyc(2);
		chk(32'(tickIrq), 32'h0000_0000);
		rc(PCT_IDX_TICKCSR, 8'h38);
		rc(PCT_IDX_TICKCSR, 8'h18);
		@(posedge core_clk);
		halt <= 1'b1;
		xfer(1'b0, PCT_IDX_TICKCV, 8'h00, 2'b00);
		cnt = rd[7:0];
		cyc(10);
		rc(PCT_IDX_TICKCV, cnt);
		@(posedge core_clk);
		halt <= 1'b0;
		wr(PCT_IDX_TICKCSR, 8'h00);
		wr(PCT_IDX_TICKCV, 8'h00);
		wr(PCT_IDX_TICKCSR, 8'h0f);
		cyc(600);
		rc(PCT_IDX_TICKCV, 8'h02);
		wr(PCT_IDX_TICKCSR, 8'h48);
		wr(PCT_IDX_ARR, 8'h00);
		wr(PCT_IDX_CAR, 8'h00);
		wr(PCT_IDX_TICKCV, 8'h00);
		wr(PCT_IDX_CSR, 8'h08);
		cyc(600);
		rc(PCT_IDX_TICKCV, 8'h02);
		wr(PCT_IDX_CSR, 8'h0a);
		cyc(1);
		chk(32'(artIrq), 32'h0000_0001);
		rc(PCT_IDX_CSR, 8'h0b);
		cyc(1);
		chk(32'(artIrq), 32'h0000_0000);
	endtask : tTick
	////////////////////////////////////////////////////////////////////////
	task automatic closeOut();
		$display("checks %0d mismatches %0d", checked, badCount);
		if (badCount == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : closeOut
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		badCount++;
		closeOut();
	end
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		halt = 1'b0;
		cpuIntMask = 1'b0;
		extClkIn = 1'b0;
		srcLvl = 2'b10;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		tRegs();
		tPwm();
		tCap();
		tTick();
		closeOut();
	end
endmodule : tb
